// File: logic/msd_pkg.sv
// Package of constants and types for the memory space decoder
package msd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_POINTER_CFG = 8'h00;
  localparam logic [7:0] OFS_MEMORY_CTL = 8'h04;
  localparam logic [7:0] OFS_AUX_CTL = 8'h08;
  localparam logic [7:0] OFS_PAGE = 8'h0c;
  localparam logic [7:0] OFS_PIN_CTL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SIG_SEL_BIT = 3;
  localparam int FLASH_EN_BIT = 3;
  localparam int PROG_SEL_BIT = 7;
  localparam int FORCE_OFF_BIT = 1;
  localparam logic [7:0] RST_POINTER_CFG = 8'h00;
  localparam logic [7:0] RST_MEMORY_CTL = 8'h00;
  localparam logic [7:0] RST_AUX_CTL = 8'h00;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [3:0] RST_PIN_CTL = 4'h0;

  // ----------------------------------------------------------------
  // Address map boundaries
  // ----------------------------------------------------------------
  localparam logic [15:0] EXTRA_TOP = 16'h1000;
  localparam logic [15:0] FLASH_TOP = 16'h3000;
  localparam logic [7:0] PAGE_LIMIT = 8'h10;
  localparam logic [15:0] USER_BASE = 16'h0100;
  localparam logic [15:0] USER_TOP = 16'h0200;
  localparam logic [15:0] MAKER_TOP = 16'h0080;
  localparam logic [15:0] VECTOR_SPAN = 16'h0053;
  localparam logic [7:0] CAL_INDEX = 8'h80;
  localparam logic [7:0] HOLE_DATA = 8'hff;

  // ----------------------------------------------------------------
  // CPU access kinds and decoded targets
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_DIRECT = 3'h0,
    KIND_INDIRECT = 3'h1,
    KIND_EXT8 = 3'h2,
    KIND_EXT16 = 3'h3,
    KIND_FETCH = 3'h4,
    KIND_TABLE = 3'h5
  } msd_kind_e;

  typedef enum logic [8:0] {
    TGT_NONE = 9'h000,
    TGT_DIRECT_RAM = 9'h001,
    TGT_INDIRECT_RAM = 9'h002,
    TGT_IO_REG = 9'h004,
    TGT_EXTRA_RAM = 9'h008,
    TGT_FLASH_DATA = 9'h010,
    TGT_OFFCHIP = 9'h020,
    TGT_CODE = 9'h040,
    TGT_SIGNATURE = 9'h080,
    TGT_PROG_CODE = 9'h100
  } msd_tgt_e;

  localparam logic [1:0] SIG_HOLE = 2'h0;
  localparam logic [1:0] SIG_MAKER = 2'h1;
  localparam logic [1:0] SIG_USER = 2'h2;

endpackage : msd_pkg

// File: logic/msd_sig_if.sv
// Interface between the decoder and the signature arrays
`timescale 1ns/1ps
`default_nettype none
interface msd_sig_if;
  logic rd_en;
  logic [1:0] rd_sel;
  logic [7:0] rd_idx;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [8:0] prog_idx;
  logic [7:0] prog_data;
  logic [7:0] cal_byte;

  modport dec (output rd_en, rd_sel, rd_idx, wr_en, wr_idx, wr_data, prog_idx,
    input rd_data, prog_data, cal_byte);
  modport arr (input rd_en, rd_sel, rd_idx, wr_en, wr_idx, wr_data, prog_idx,
    output rd_data, prog_data, cal_byte);
endinterface : msd_sig_if
`default_nettype wire

// File: logic/msd_sig_array.sv
// Signature arrays: writable user array and fixed maker array
`timescale 1ns/1ps
`default_nettype none
module msd_sig_array #(
  parameter logic [23:0] DEVICE_ID = 24'h5a_a5_01, // Arbitrary value
  parameter logic [7:0] CAL_DEFAULT = 8'h80
) (
  input wire logic clk,
  input wire logic reset,
  msd_sig_if.arr sig
);

  typedef struct packed {
    logic [7:0] rd_data;
    logic [7:0] prog_data;
    logic [7:0] cal_byte;
  } msd_arr_s;

  msd_arr_s st_reg;
  msd_arr_s st_next;
  logic [7:0] user_mem [0:255];

  // Maker array content: identification bytes, rest erased
  function automatic logic [7:0] msd_maker(input logic [7:0] idx);
    case (idx)
      8'h00: msd_maker = DEVICE_ID[23:16];
      8'h01: msd_maker = DEVICE_ID[15:8];
      8'h02: msd_maker = DEVICE_ID[7:0];
      default: msd_maker = msd_pkg::HOLE_DATA;
    endcase
  endfunction : msd_maker

  // Calibration byte lands in the second page on every reset
  always_ff @(posedge clk) begin
    if (reset) begin
      user_mem[msd_pkg::CAL_INDEX] <= CAL_DEFAULT; // RULE16
    end else if (sig.wr_en) begin
      user_mem[sig.wr_idx] <= sig.wr_data; // RULE14
    end
  end

  always_comb begin
    st_next = st_reg;
    if (sig.rd_en) begin
      case (sig.rd_sel)
        msd_pkg::SIG_USER: st_next.rd_data = user_mem[sig.rd_idx]; // RULE13
        msd_pkg::SIG_MAKER: st_next.rd_data = msd_maker(sig.rd_idx); // RULE17
        default: st_next.rd_data = msd_pkg::HOLE_DATA;
      endcase
    end
    // Programmer reads are never gated by security
    if (sig.prog_idx[8]) begin
      st_next.prog_data = user_mem[sig.prog_idx[7:0]]; // RULE15
    end else begin
      st_next.prog_data = msd_maker(sig.prog_idx[7:0]);
    end
    st_next.cal_byte = user_mem[msd_pkg::CAL_INDEX];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sig.rd_data = st_reg.rd_data;
  assign sig.prog_data = st_reg.prog_data;
  assign sig.cal_byte = st_reg.cal_byte;

endmodule : msd_sig_array
`default_nettype wire

// File: logic/msd_decoder.sv
// Memory space decoder with APB control registers
// Contract
// [RULE1] Direct 00H-7FH selects internal RAM
// [RULE2] Indirect pointer reaches all 256 RAM bytes
// [RULE3] Direct 80H-FFH selects I/O registers
// [RULE4] External moves 0000H-0FFFH hit extra RAM
// [RULE5] External moves 1000H-2FFFH hit flash data
// [RULE6] External moves 3000H-FFFFH go off-chip
// [RULE7] Code fetches use linear 64K flash
// [RULE8] No off-chip code; strobe pins are GPIO
// [RULE9] Address latch pulses only on off-chip moves
// [RULE10] Vectors lie in first 83 program bytes
// [RULE11] Signature select redirects pointer table reads
// [RULE12] User 0100h-01FFh, maker 0000h-007Fh
// [RULE13] 256-byte user and 128-byte maker arrays
// [RULE14] Program and signature select: moves hit user
// [RULE15] Security blocks writes; programmer reads allowed
// [RULE16] Second user page holds oscillator calibration
// [RULE17] Maker array holds device identification
// [RULE18] Flash data needs enable set, program clear
// [RULE19] Page register extends 8-bit moves; 10H+ off-chip
// [RULE20] Force bit sends all moves off-chip
// [RULE21] 8-bit moves never reach flash data
// [RULE22] Signature select resets to zero
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder #(
  parameter logic [23:0] DEVICE_ID = 24'h5a_a5_01, // Arbitrary value
  parameter logic [7:0] CAL_DEFAULT = 8'h80
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_req,
  input wire logic [2:0] cpu_kind,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_we,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_valid,
  output logic [8:0] cpu_target,
  output logic [15:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] sig_rdata,
  output logic vector_fetch,
  output logic ale,
  output logic [7:0] upper_addr,
  input wire logic security_lock,
  input wire logic [8:0] prog_rd_addr,
  output logic [7:0] prog_rd_data,
  output logic [7:0] rc_cal_byte,
  input wire logic program_store_strobe_i,
  output logic program_store_strobe_o,
  output logic program_store_strobe_oe,
  input wire logic external_access_pin_i,
  output logic external_access_pin_o,
  output logic external_access_pin_oe
);

  typedef struct packed {
    logic [7:0] pointer_config_reg;
    logic [7:0] memory_control_reg;
    logic [7:0] auxiliary_control_reg;
    logic [7:0] page;
    logic [3:0] pin_ctl;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] pin_in;
    logic [8:0] tgt;
    logic [15:0] maddr;
    logic mwe;
    logic [7:0] mwdata;
    logic valid;
    logic ale;
    logic [7:0] upper;
    logic vec;
    logic [31:0] prdata;
    logic pslverr;
  } msd_top_s;

  msd_top_s st_reg;
  msd_top_s st_next;
  msd_sig_if sig ();

  // ----------------------------------------------------------------
  // Signature arrays
  // ----------------------------------------------------------------
  msd_sig_array #(
    .DEVICE_ID(DEVICE_ID),
    .CAL_DEFAULT(CAL_DEFAULT)
  ) u_sig (
    .clk(clk),
    .reset(reset),
    .sig(sig)
  );

  logic signature_read_select;
  logic program_access_select;
  logic flash_data_enable;
  logic force_offchip_data;
  logic [8:0] tgt_d;
  logic [15:0] addr_d;
  logic offchip_d;
  logic [1:0] sig_sel_d;
  logic apb_wr;
  logic apb_setup;

  assign signature_read_select = st_reg.pointer_config_reg[msd_pkg::SIG_SEL_BIT];
  assign program_access_select = st_reg.memory_control_reg[msd_pkg::PROG_SEL_BIT];
  assign flash_data_enable = st_reg.memory_control_reg[msd_pkg::FLASH_EN_BIT];
  assign force_offchip_data = st_reg.auxiliary_control_reg[msd_pkg::FORCE_OFF_BIT];
  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    tgt_d = msd_pkg::TGT_NONE;
    addr_d = cpu_addr;
    sig_sel_d = msd_pkg::SIG_HOLE;
    case (msd_pkg::msd_kind_e'(cpu_kind))
      msd_pkg::KIND_DIRECT: begin
        addr_d = {8'h00, cpu_addr[7:0]};
        if (cpu_addr[7]) begin
          tgt_d = msd_pkg::TGT_IO_REG; // RULE3
        end else begin
          tgt_d = msd_pkg::TGT_DIRECT_RAM; // RULE1
        end
      end
      msd_pkg::KIND_INDIRECT: begin
        addr_d = {8'h00, cpu_addr[7:0]};
        tgt_d = msd_pkg::TGT_INDIRECT_RAM; // RULE2
      end
      msd_pkg::KIND_EXT8: begin
        addr_d = {st_reg.page, cpu_addr[7:0]}; // RULE19
        if (force_offchip_data || st_reg.page >= msd_pkg::PAGE_LIMIT) begin
          tgt_d = msd_pkg::TGT_OFFCHIP; // RULE19 RULE20 RULE21
        end else begin
          tgt_d = msd_pkg::TGT_EXTRA_RAM; // RULE4
        end
      end
      msd_pkg::KIND_EXT16: begin
        if (force_offchip_data) begin
          tgt_d = msd_pkg::TGT_OFFCHIP; // RULE20
        end else if (program_access_select && signature_read_select) begin
          tgt_d = msd_pkg::TGT_SIGNATURE; // RULE14
          sig_sel_d = msd_pkg::SIG_USER;
        end else if (program_access_select) begin
          tgt_d = msd_pkg::TGT_PROG_CODE;
        end else if (cpu_addr < msd_pkg::EXTRA_TOP) begin
          tgt_d = msd_pkg::TGT_EXTRA_RAM; // RULE4
        end else if (cpu_addr < msd_pkg::FLASH_TOP && flash_data_enable) begin
          tgt_d = msd_pkg::TGT_FLASH_DATA; // RULE5 RULE18
        end else begin
          tgt_d = msd_pkg::TGT_OFFCHIP; // RULE6
        end
      end
      msd_pkg::KIND_FETCH: begin
        tgt_d = msd_pkg::TGT_CODE; // RULE7 RULE8
      end
      msd_pkg::KIND_TABLE: begin
        if (signature_read_select) begin
          tgt_d = msd_pkg::TGT_SIGNATURE; // RULE11
          if (cpu_addr >= msd_pkg::USER_BASE && cpu_addr < msd_pkg::USER_TOP) begin
            sig_sel_d = msd_pkg::SIG_USER; // RULE12
          end else if (cpu_addr < msd_pkg::MAKER_TOP) begin
            sig_sel_d = msd_pkg::SIG_MAKER; // RULE12
          end
        end else begin
          tgt_d = msd_pkg::TGT_CODE; // RULE7
        end
      end
      default: begin
        tgt_d = msd_pkg::TGT_NONE;
      end
    endcase
  end

  assign offchip_d = cpu_req && tgt_d == msd_pkg::TGT_OFFCHIP;

  // Signature array access
  assign sig.rd_en = cpu_req && tgt_d == msd_pkg::TGT_SIGNATURE && !cpu_we;
  assign sig.rd_sel = sig_sel_d;
  assign sig.rd_idx = cpu_addr[7:0];
  assign sig.wr_en = cpu_req && cpu_we && tgt_d == msd_pkg::TGT_SIGNATURE &&
    cpu_kind == msd_pkg::KIND_EXT16 && !security_lock; // RULE14 RULE15
  assign sig.wr_idx = cpu_addr[7:0];
  assign sig.wr_data = cpu_wdata;
  assign sig.prog_idx = prog_rd_addr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Pin synchronisers: a change counts once stages two and three agree
    st_next.sync1 = {external_access_pin_i, program_store_strobe_i};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    if (st_reg.sync2 == st_reg.sync3) begin
      st_next.pin_in = st_reg.sync3;
    end
    // Bus write takes effect at the access edge
    if (apb_wr) begin
      case (paddr)
        msd_pkg::OFS_POINTER_CFG: st_next.pointer_config_reg = pwdata[7:0]; // RULE11
        msd_pkg::OFS_MEMORY_CTL: st_next.memory_control_reg = pwdata[7:0];
        msd_pkg::OFS_AUX_CTL: st_next.auxiliary_control_reg = pwdata[7:0];
        msd_pkg::OFS_PAGE: st_next.page = pwdata[7:0];
        msd_pkg::OFS_PIN_CTL: st_next.pin_ctl = pwdata[3:0]; // RULE8
        default: st_next.pin_ctl = st_reg.pin_ctl;
      endcase
    end
    // Read data is prepared during setup, shown in the access phase
    if (apb_setup) begin
      st_next.pslverr = 1'b0;
      case (paddr)
        msd_pkg::OFS_POINTER_CFG: st_next.prdata = {24'h000000, st_reg.pointer_config_reg};
        msd_pkg::OFS_MEMORY_CTL: st_next.prdata = {24'h000000, st_reg.memory_control_reg};
        msd_pkg::OFS_AUX_CTL: st_next.prdata = {24'h000000, st_reg.auxiliary_control_reg};
        msd_pkg::OFS_PAGE: st_next.prdata = {24'h000000, st_reg.page};
        msd_pkg::OFS_PIN_CTL: st_next.prdata = {28'h0000000, st_reg.pin_ctl};
        msd_pkg::OFS_STATUS: begin
          st_next.prdata = {7'h00, st_reg.tgt, 13'h0000, security_lock, st_reg.pin_in};
        end
        default: begin
          st_next.prdata = 32'h00000000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    // CPU access result, one cycle after the request
    st_next.valid = cpu_req;
    st_next.ale = offchip_d; // RULE9
    st_next.vec = cpu_req && cpu_kind == msd_pkg::KIND_FETCH &&
      cpu_addr < msd_pkg::VECTOR_SPAN; // RULE10
    if (cpu_req) begin
      st_next.tgt = tgt_d;
      st_next.maddr = addr_d;
      st_next.mwe = cpu_we;
      st_next.mwdata = cpu_wdata;
      // Upper port keeps its value for paged moves beyond extra RAM
      if (offchip_d && cpu_kind == msd_pkg::KIND_EXT16) begin
        st_next.upper = cpu_addr[15:8]; // RULE6
      end else if (offchip_d && st_reg.page < msd_pkg::PAGE_LIMIT) begin
        st_next.upper = st_reg.page; // RULE19
      end
    end else begin
      st_next.mwe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.pointer_config_reg <= msd_pkg::RST_POINTER_CFG; // RULE22
      st_reg.memory_control_reg <= msd_pkg::RST_MEMORY_CTL;
      st_reg.auxiliary_control_reg <= msd_pkg::RST_AUX_CTL;
      st_reg.page <= msd_pkg::RST_PAGE;
      st_reg.pin_ctl <= msd_pkg::RST_PIN_CTL;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = st_reg.pslverr & psel & penable;
  assign cpu_valid = st_reg.valid;
  assign cpu_target = st_reg.tgt;
  assign mem_addr = st_reg.maddr;
  assign mem_we = st_reg.mwe;
  assign mem_wdata = st_reg.mwdata;
  assign sig_rdata = sig.rd_data;
  assign vector_fetch = st_reg.vec;
  assign ale = st_reg.ale;
  assign upper_addr = st_reg.upper;
  assign prog_rd_data = sig.prog_data;
  assign rc_cal_byte = sig.cal_byte;
  assign program_store_strobe_o = st_reg.pin_ctl[0]; // RULE8
  assign program_store_strobe_oe = st_reg.pin_ctl[1];
  assign external_access_pin_o = st_reg.pin_ctl[2]; // RULE8
  assign external_access_pin_oe = st_reg.pin_ctl[3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_DIRECT_LOW: assert property (cpu_req && cpu_kind == msd_pkg::KIND_DIRECT && // RULE1
    !cpu_addr[7] |=> cpu_target == msd_pkg::TGT_DIRECT_RAM)
    else $error("Low direct address missed internal RAM");
  AST_DIRECT_HIGH: assert property (cpu_req && cpu_kind == msd_pkg::KIND_DIRECT && // RULE3
    cpu_addr[7] |=> cpu_target == msd_pkg::TGT_IO_REG && mem_addr[7])
    else $error("High direct address missed I/O space");
  AST_INDIRECT: assert property (cpu_req && cpu_kind == msd_pkg::KIND_INDIRECT |=> // RULE2
    cpu_target == msd_pkg::TGT_INDIRECT_RAM && mem_addr[7:0] == $past(cpu_addr[7:0]))
    else $error("Indirect access misrouted");
  AST_EXTRA: assert property (cpu_req && cpu_kind == msd_pkg::KIND_EXT16 && // RULE4
    !force_offchip_data && !program_access_select && cpu_addr < msd_pkg::EXTRA_TOP
    |=> cpu_target == msd_pkg::TGT_EXTRA_RAM)
    else $error("Low wide move missed extra RAM");
  AST_FLASH: assert property (cpu_req && cpu_kind == msd_pkg::KIND_EXT16 ##1 // RULE5
    cpu_target == msd_pkg::TGT_FLASH_DATA |->
    $past(flash_data_enable) && !$past(program_access_select) &&
    $past(cpu_addr) >= msd_pkg::EXTRA_TOP && $past(cpu_addr) < msd_pkg::FLASH_TOP)
    else $error("Flash data selected while disabled");
  AST_FORCE: assert property (cpu_req && force_offchip_data && // RULE20
    (cpu_kind == msd_pkg::KIND_EXT8 || cpu_kind == msd_pkg::KIND_EXT16)
    |=> cpu_target == msd_pkg::TGT_OFFCHIP && ale ##1 !ale || cpu_valid)
    else $error("Forced move stayed on chip");
  AST_ALE_ONLY: assert property (ale |-> cpu_valid && cpu_target == msd_pkg::TGT_OFFCHIP) // RULE9
    else $error("Address latch pulsed without off-chip move");
  AST_FETCH: assert property (cpu_req && cpu_kind == msd_pkg::KIND_FETCH |=> // RULE7
    cpu_target == msd_pkg::TGT_CODE && !ale)
    else $error("Fetch left program flash");
  AST_PAGE_HIGH: assert property (cpu_req && cpu_kind == msd_pkg::KIND_EXT8 && // RULE19
    st_reg.page >= msd_pkg::PAGE_LIMIT |=> cpu_target == msd_pkg::TGT_OFFCHIP &&
    $stable(upper_addr))
    else $error("High page changed upper port or stayed on chip");
  AST_SIG_TABLE: assert property (cpu_req && cpu_kind == msd_pkg::KIND_TABLE && // RULE11
    signature_read_select |=> cpu_target == msd_pkg::TGT_SIGNATURE)
    else $error("Table read ignored signature select");
  AST_SIG_RESET: assert property (@(posedge clk) disable iff (1'b0) // RULE22
    $fell(reset) |-> !signature_read_select)
    else $error("Signature select not cleared by reset");

  COV_OFFCHIP: cover property (cpu_req && cpu_kind == msd_pkg::KIND_EXT16 ##1 ale);
  COV_SIG_READ: cover property (sig.rd_en && sig.rd_sel == msd_pkg::SIG_USER);
  COV_FLASH: cover property (cpu_target == msd_pkg::TGT_FLASH_DATA && cpu_valid);

endmodule : msd_decoder
`default_nettype wire

// File: dv/msd_cpu_model.sv
// CPU-side model that issues one decoder request at a time
`timescale 1ns/1ps
`default_nettype none
module msd_cpu_model (
  input wire logic clk,
  output logic cpu_req,
  output logic [2:0] cpu_kind,
  output logic [15:0] cpu_addr,
  output logic cpu_we,
  output logic [7:0] cpu_wdata
);
  initial begin
    cpu_req = 1'b0;
    cpu_kind = 3'h0;
    cpu_addr = 16'h0000;
    cpu_we = 1'b0;
    cpu_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // One-cycle request strobe
  // ----------------------------------------------------------------
  // Between requests the qualifiers show the inverse of the last value
  task automatic issue(input logic [2:0] k, input logic [15:0] a, input logic w,
    input logic [7:0] d);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_kind <= k;
    cpu_addr <= a;
    cpu_we <= w;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
    cpu_kind <= ~k;
    cpu_addr <= ~a;
    cpu_we <= ~w;
    cpu_wdata <= ~d;
    #1;
  endtask : issue
endmodule : msd_cpu_model
`default_nettype wire

// File: dv/msd_decoder_test.sv
// Self-checking testbench of the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_test;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err_resp, security_lock, ea_i;
  logic cpu_req, cpu_we, cpu_valid, mem_we, vector_fetch, ale, ps_i, ps_o, ps_oe, ea_o, ea_oe;
  logic [2:0] cpu_kind;
  logic [7:0] paddr, cpu_wdata, mem_wdata, sig_rdata, upper_addr, prog_rd_data, rc_cal_byte;
  logic [8:0] cpu_target, prog_rd_addr;
  logic [15:0] cpu_addr, mem_addr;
  logic [31:0] pwdata, prdata, rd;
  int err_count, num_checks, cycles;

  msd_cpu_model cm (.clk(clk), .cpu_req(cpu_req), .cpu_kind(cpu_kind), .cpu_addr(cpu_addr),
    .cpu_we(cpu_we), .cpu_wdata(cpu_wdata));

  msd_decoder dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_kind(cpu_kind), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
    .cpu_wdata(cpu_wdata), .cpu_valid(cpu_valid), .cpu_target(cpu_target),
    .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .sig_rdata(sig_rdata),
    .vector_fetch(vector_fetch), .ale(ale), .upper_addr(upper_addr),
    .security_lock(security_lock), .prog_rd_addr(prog_rd_addr),
    .prog_rd_data(prog_rd_data), .rc_cal_byte(rc_cal_byte),
    .program_store_strobe_i(ps_i), .program_store_strobe_o(ps_o),
    .program_store_strobe_oe(ps_oe), .external_access_pin_i(ea_i),
    .external_access_pin_o(ea_o), .external_access_pin_oe(ea_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_resp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cpu(input logic [2:0] k, input logic [15:0] a, input logic w,
    input logic [7:0] d, input logic [8:0] t);
    cm.issue(k, a, w, d);
    check(cpu_valid, 1'b1);
    check(cpu_target, t);
  endtask : cpu

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, msd_pkg::OFS_POINTER_CFG, 32'h0);
    check(rd, msd_pkg::RST_POINTER_CFG);
    apb(1'b0, 8'h40, 32'h0);
    check(err_resp, 1'b1);
    check(rc_cal_byte, 8'h80);
  endtask : t_reset

  task automatic t_internal();
    cpu(msd_pkg::KIND_DIRECT, 16'h007f, 1'b0, 8'h00, msd_pkg::TGT_DIRECT_RAM);
    cpu(msd_pkg::KIND_DIRECT, 16'h0080, 1'b0, 8'h00, msd_pkg::TGT_IO_REG);
    cpu(msd_pkg::KIND_INDIRECT, 16'h00ff, 1'b0, 8'h00, msd_pkg::TGT_INDIRECT_RAM);
    check(mem_addr, 16'h00ff);
    check(ale, 1'b0);
  endtask : t_internal

  task automatic t_external();
    cpu(msd_pkg::KIND_EXT16, 16'h0fff, 1'b0, 8'h00, msd_pkg::TGT_EXTRA_RAM);
    check(ale, 1'b0);
    cpu(msd_pkg::KIND_EXT16, 16'h1000, 1'b0, 8'h00, msd_pkg::TGT_OFFCHIP);
    apb(1'b1, msd_pkg::OFS_MEMORY_CTL, 32'h08);
    cpu(msd_pkg::KIND_EXT16, 16'h2fff, 1'b0, 8'h00, msd_pkg::TGT_FLASH_DATA);
    cpu(msd_pkg::KIND_EXT16, 16'h3000, 1'b1, 8'h5c, msd_pkg::TGT_OFFCHIP);
    check(ale, 1'b1);
    check(upper_addr, 8'h30);
    check(mem_we, 1'b1);
    check(mem_wdata, 8'h5c);
    apb(1'b1, msd_pkg::OFS_AUX_CTL, 32'h02);
    cpu(msd_pkg::KIND_EXT16, 16'h0000, 1'b0, 8'h00, msd_pkg::TGT_OFFCHIP);
    apb(1'b1, msd_pkg::OFS_AUX_CTL, 32'h00);
  endtask : t_external

  task automatic t_page();
    cpu(msd_pkg::KIND_EXT16, 16'h4000, 1'b0, 8'h00, msd_pkg::TGT_OFFCHIP);
    apb(1'b1, msd_pkg::OFS_PAGE, 32'h0f);
    cpu(msd_pkg::KIND_EXT8, 16'h0034, 1'b0, 8'h00, msd_pkg::TGT_EXTRA_RAM);
    check(mem_addr, 16'h0f34);
    apb(1'b1, msd_pkg::OFS_PAGE, 32'h10);
    cpu(msd_pkg::KIND_EXT8, 16'h0000, 1'b0, 8'h00, msd_pkg::TGT_OFFCHIP);
    check(upper_addr, 8'h40);
  endtask : t_page

  task automatic t_code();
    cpu(msd_pkg::KIND_FETCH, 16'h0052, 1'b0, 8'h00, msd_pkg::TGT_CODE);
    check(vector_fetch, 1'b1);
    cpu(msd_pkg::KIND_FETCH, 16'h0053, 1'b0, 8'h00, msd_pkg::TGT_CODE);
    check(vector_fetch, 1'b0);
    cpu(msd_pkg::KIND_TABLE, 16'hffff, 1'b0, 8'h00, msd_pkg::TGT_CODE);
    check(mem_addr, 16'hffff);
    check({ps_oe, ea_oe, ale}, 3'h0);
  endtask : t_code

  task automatic t_sig();
    apb(1'b1, msd_pkg::OFS_POINTER_CFG, 32'h08);
    cpu(msd_pkg::KIND_TABLE, 16'h0000, 1'b0, 8'h00, msd_pkg::TGT_SIGNATURE);
    check(sig_rdata, 8'h5a);
    cpu(msd_pkg::KIND_TABLE, 16'h007f, 1'b0, 8'h00, msd_pkg::TGT_SIGNATURE);
    check(sig_rdata, 8'hff);
    cpu(msd_pkg::KIND_TABLE, 16'h0180, 1'b0, 8'h00, msd_pkg::TGT_SIGNATURE);
    check(sig_rdata, 8'h80);
    apb(1'b1, msd_pkg::OFS_MEMORY_CTL, 32'h88);
    cpu(msd_pkg::KIND_EXT16, 16'h0105, 1'b1, 8'ha5, msd_pkg::TGT_SIGNATURE);
    security_lock <= 1'b1;
    cpu(msd_pkg::KIND_EXT16, 16'h0105, 1'b1, 8'h3c, msd_pkg::TGT_SIGNATURE);
    cpu(msd_pkg::KIND_TABLE, 16'h0105, 1'b0, 8'h00, msd_pkg::TGT_SIGNATURE);
    check(sig_rdata, 8'ha5);
    prog_rd_addr <= 9'h105;
    repeat (2) @(posedge clk);
    #1;
    check(prog_rd_data, 8'ha5);
    security_lock <= 1'b0;
    apb(1'b1, msd_pkg::OFS_POINTER_CFG, 32'h00);
    cpu(msd_pkg::KIND_EXT16, 16'h2000, 1'b0, 8'h00, msd_pkg::TGT_PROG_CODE);
    cpu(msd_pkg::KIND_TABLE, 16'h0000, 1'b0, 8'h00, msd_pkg::TGT_CODE);
  endtask : t_sig

  task automatic t_rerun();
    apb(1'b1, msd_pkg::OFS_POINTER_CFG, 32'h08);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, msd_pkg::OFS_POINTER_CFG, 32'h0);
    check(rd, msd_pkg::RST_POINTER_CFG);
    check(rc_cal_byte, 8'h80);
    cpu(msd_pkg::KIND_TABLE, 16'h0000, 1'b0, 8'h00, msd_pkg::TGT_CODE);
  endtask : t_rerun

  task automatic t_pins();
    ps_i <= 1'b1;
    ea_i <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, msd_pkg::OFS_STATUS, 32'h0);
    check(rd, {7'h00, msd_pkg::TGT_CODE, 16'h0003});
    apb(1'b1, msd_pkg::OFS_PIN_CTL, 32'h0f);
    @(posedge clk);
    #1;
    check({ps_o, ps_oe, ea_o, ea_oe}, 4'hf);
  endtask : t_pins

  initial begin
    {psel, penable, pwrite, security_lock, ps_i, ea_i} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    prog_rd_addr = 9'h000;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_internal();
    t_external();
    t_page();
    t_code();
    t_sig();
    t_rerun();
    t_pins();
    test_done();
  end
endmodule : msd_decoder_test
`default_nettype wire
